// ==== hw/dsip_host.sv ====
// dsip_host: host side driver of the dac serial input port
// drives data, clock and latch pins; mode chosen by an input strap level
// the link clock is derived here from mclk, so there is a single domain
`timescale 1ns/1ps
`default_nettype none

// Operation
// (RQ1) async mode leaves the latch pin released high, three-wire mode drives it.
// (RQ2) in async mode the clock out runs at sixteen times the bit rate.
// (RQ3) async clock is near 2.4 MHz for a 150 kbps bit rate.
// (RQ4) data, clock and latch outputs take the roles of mosi, sck and select.
// (RQ5) the three-wire clock idles low, mode 0, at about 1 MHz.
// (RQ6) latch goes low before the first data bit is shifted.
// (RQ7) a word goes out as two bytes of eight pulses, valid on rising edges.
// (RQ8) the upper byte is sent first, then the lower byte.
// (RQ9) latch rises after all sixteen bits to load the word.
// (RQ10) general output, shift clock and serial out map to latch, clock, data.
// (RQ11) the device shifts data on each rising clock edge.
// (RQ12) the clock stays idle while the latch updates the dac.
// (RQ13) async words are framed by a start bit and a stop bit.
// (RQ14) the device passes shifted bits out on its data output for chaining.
// (RQ15) the device samples each async bit at its centre over sixteen clocks.
// (RQ16) the device drops a frame whose stop bit reads low.
module dsip_host (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  // user side
  input wire logic async_mode,
  input wire logic wr_req,
  input wire logic [15:0] wr_word,
  output logic busy,
  output logic wr_done,
  // pins to the device, and the chained word read back
  output logic dac_data,
  output logic dac_clk,
  output logic dac_latch,
  output logic dac_latch_oe,
  input wire logic dac_sdo,
  output logic sdo_word_valid,
  output logic [15:0] sdo_word
);

  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_LOW, S_HIGH, S_LATCH} dsip_state_type;

  typedef struct packed {
    dsip_state_type st;
    logic mode;
    logic [15:0] sh;
    logic [15:0] rx;
    logic [4:0] bitn;
    logic [3:0] tick;
    logic [7:0] div;
    logic busy;
    logic done;
    logic data;
    logic clk;
    logic latch;
    logic oe;
    logic sdo_s1;
    logic sdo_s2;
    logic rxv;
  } dsip_regs_type;

  dsip_regs_type r_ff, nxt_r;

  // half period in mclk cycles for the selected mode
  function automatic logic [7:0] half_of(input logic m);
    half_of = m ? dsip_pkg::ASYNC_HALF : dsip_pkg::SPI_HALF;
  endfunction

  // chain capture: take the far end's output bit just before the rising edge
  // shifts it, so the word read back is the one the device held before;
  // in async mode nothing is chained and the capture register holds
  function automatic logic [15:0] chain_in(input logic [15:0] acc, input logic bit_in,
                                           input logic m);
    chain_in = m ? acc : {acc[14:0], bit_in};
  endfunction

  // next state; the divider runs only while a word is in flight so clk idles low
  always_comb begin
    nxt_r = r_ff;
    nxt_r.done = 1'b0;
    nxt_r.rxv = 1'b0;
    nxt_r.sdo_s1 = dac_sdo;
    nxt_r.sdo_s2 = r_ff.sdo_s1;
    case (r_ff.st)
      S_IDLE: begin
        nxt_r.clk = 1'b0;
        nxt_r.data = 1'b1;
        if (wr_req) begin
          nxt_r.mode = async_mode;
          nxt_r.sh = wr_word;
          nxt_r.bitn = 5'h00;
          nxt_r.tick = 4'h0;
          nxt_r.div = half_of(async_mode);
          nxt_r.busy = 1'b1;
          // (RQ1) async releases latch
          nxt_r.oe = ~async_mode;
          // (RQ6) latch low first
          nxt_r.latch = async_mode;
          // (RQ13) start bit low
          nxt_r.data = async_mode ? 1'b0 : wr_word[15];
          nxt_r.st = S_SETUP;
        end
      end
      S_SETUP: begin
        // a full half period of setup before the first rising edge
        if (r_ff.div == 8'h01) begin
          nxt_r.div = half_of(r_ff.mode);
          nxt_r.clk = 1'b1;
          // (RQ14) sample chain before the edge
          nxt_r.rx = chain_in(r_ff.rx, r_ff.sdo_s2, r_ff.mode);
          nxt_r.st = S_HIGH;
        end else begin
          nxt_r.div = r_ff.div - 8'h01;
        end
      end
      S_HIGH: begin
        if (r_ff.div == 8'h01) begin
          nxt_r.div = half_of(r_ff.mode);
          nxt_r.clk = 1'b0;
          nxt_r.st = S_LOW;
          if (!r_ff.mode) begin
            // (RQ7) next bit on falling edge
            nxt_r.sh = {r_ff.sh[14:0], 1'b0};
            nxt_r.data = r_ff.sh[14];
            // (RQ9) sixteen bits then latch
            if (r_ff.bitn == dsip_pkg::LAST_SPI_BIT) begin
              nxt_r.st = S_LATCH;
            end
            nxt_r.bitn = r_ff.bitn + 5'h01;
          end else begin
            // (RQ2) sixteen clocks per bit
            nxt_r.tick = r_ff.tick + 4'h1;
            if (r_ff.tick == dsip_pkg::LAST_TICK) begin
              nxt_r.bitn = r_ff.bitn + 5'h01;
              if (r_ff.bitn == dsip_pkg::FRAME_BITS - 5'h01) begin
                nxt_r.st = S_LATCH;
              end else if (r_ff.bitn == dsip_pkg::FRAME_BITS - 5'h02) begin
                // (RQ13) stop bit high
                nxt_r.data = 1'b1;
              end else begin
                // (RQ8) upper byte first
                nxt_r.data = r_ff.sh[15];
                nxt_r.sh = {r_ff.sh[14:0], 1'b0};
              end
            end
          end
        end else begin
          nxt_r.div = r_ff.div - 8'h01;
        end
      end
      S_LOW: begin
        if (r_ff.div == 8'h01) begin
          nxt_r.div = half_of(r_ff.mode);
          nxt_r.clk = 1'b1;
          // (RQ14) sample chain before the edge
          nxt_r.rx = chain_in(r_ff.rx, r_ff.sdo_s2, r_ff.mode);
          nxt_r.st = S_HIGH;
        end else begin
          nxt_r.div = r_ff.div - 8'h01;
        end
      end
      S_LATCH: begin
        // (RQ12) clock held low here
        nxt_r.clk = 1'b0;
        if (r_ff.div == 8'h01) begin
          // (RQ9) rising latch loads word
          nxt_r.latch = 1'b1;
          nxt_r.data = 1'b1;
          nxt_r.busy = 1'b0;
          nxt_r.done = 1'b1;
          nxt_r.rxv = ~r_ff.mode;
          nxt_r.st = S_IDLE;
        end else begin
          nxt_r.div = r_ff.div - 8'h01;
        end
      end
      default: begin
        nxt_r.st = S_IDLE;
      end
    endcase
  end

  // state register; clk_en freezes everything
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r_ff <= '{st: S_IDLE, mode: 1'b0, sh: 16'h0000, rx: 16'h0000, bitn: 5'h00,
                tick: 4'h0, div: 8'h00, busy: 1'b0, done: 1'b0, data: 1'b1,
                clk: 1'b0, latch: 1'b1, oe: 1'b0, sdo_s1: 1'b0, sdo_s2: 1'b0,
                rxv: 1'b0};
    end else if (clk_en) begin
      r_ff <= nxt_r;
    end
  end

  // outputs straight from flip-flops
  assign busy = r_ff.busy;
  assign wr_done = r_ff.done;
  assign dac_data = r_ff.data;
  assign dac_clk = r_ff.clk;
  assign dac_latch = r_ff.latch;
  assign dac_latch_oe = r_ff.oe;
  assign sdo_word_valid = r_ff.rxv;
  assign sdo_word = r_ff.rx;

  // (RQ5) clock idles low
  clk_idle_low_a: assert property (@(posedge mclk) disable iff (rst) // RQ5
    (r_ff.st == S_IDLE) |-> !dac_clk)
    else $error("link clock not low while idle");

  // (RQ6) latch low while shifting
  latch_low_shift_a: assert property (@(posedge mclk) disable iff (rst) // RQ6
    (r_ff.st == S_HIGH && !r_ff.mode) |-> !dac_latch && dac_latch_oe)
    else $error("latch high during three-wire shift");

  // (RQ1) async never drives latch
  async_release_a: assert property (@(posedge mclk) disable iff (rst) // RQ1
    (r_ff.busy && r_ff.mode) |-> !dac_latch_oe)
    else $error("latch driven in async mode");

  // (RQ12) clock low while latching
  latch_clk_quiet_a: assert property (@(posedge mclk) disable iff (rst) // RQ12
    $rose(dac_latch) && dac_latch_oe |-> !dac_clk)
    else $error("clock active at latch edge");

  // (RQ9) done with latch rise
  done_with_latch_a: assert property (@(posedge mclk) disable iff (rst) // RQ9
    wr_done |-> dac_latch && !busy)
    else $error("done without latch high");

  // (RQ7) data stable across rising edge
  data_stable_a: assert property (@(posedge mclk) disable iff (rst) // RQ7
    (clk_en && $rose(dac_clk)) |-> $stable(dac_data))
    else $error("data changed at rising clock");

  // (RQ13) async frame starts with low start bit
  start_bit_a: assert property (@(posedge mclk) disable iff (rst) // RQ13
    (clk_en && r_ff.st == S_SETUP && r_ff.mode) |-> !dac_data)
    else $error("start bit not low");

  // (RQ3) async half period bound
  async_rate_a: assert property (@(posedge mclk) disable iff (rst) // RQ3
    (r_ff.mode && r_ff.st == S_HIGH) |-> r_ff.div <= dsip_pkg::ASYNC_HALF)
    else $error("async half period too long");

  // (RQ13) async frame length
  frame_length_a: assert property (@(posedge mclk) disable iff (rst) // RQ13
    (r_ff.st == S_LATCH && r_ff.mode) |-> r_ff.bitn == dsip_pkg::FRAME_BITS)
    else $error("async frame length wrong");

  // (RQ9) sixteen bits before latch
  spi_length_a: assert property (@(posedge mclk) disable iff (rst) // RQ9
    (r_ff.st == S_LATCH && !r_ff.mode) |-> r_ff.bitn == 5'h10)
    else $error("three-wire word length wrong");

  // (RQ8) upper bit leads the word
  upper_first_a: assert property (@(posedge mclk) disable iff (rst) // RQ8
    (clk_en && r_ff.st == S_IDLE && wr_req && !async_mode) |=>
      dac_data == $past(wr_word[15]))
    else $error("first bit is not the top bit");

  // (RQ14) chained word valid only with done
  sdo_valid_a: assert property (@(posedge mclk) disable iff (rst) // RQ14
    sdo_word_valid |-> wr_done && dac_latch_oe)
    else $error("chain word valid without three-wire done");

  // (RQ13) line idles high between frames
  idle_data_a: assert property (@(posedge mclk) disable iff (rst) // RQ13
    (r_ff.st == S_IDLE) |-> dac_data)
    else $error("data line not high while idle");

  // (RQ7) bit counter stays inside the word
  spi_count_a: assert property (@(posedge mclk) disable iff (rst) // RQ7
    (r_ff.st == S_HIGH && !r_ff.mode) |-> r_ff.bitn <= dsip_pkg::LAST_SPI_BIT)
    else $error("three-wire bit count overrun");

  // (RQ4) three-wire drives the select line
  drive_select_a: assert property (@(posedge mclk) disable iff (rst) // RQ4
    (r_ff.busy && !r_ff.mode) |-> dac_latch_oe)
    else $error("latch released during three-wire word");

  // (RQ5) clock pulses only inside a word
  clk_busy_a: assert property (@(posedge mclk) disable iff (rst) // RQ5
    dac_clk |-> busy)
    else $error("link clock high while not busy");

  // (RQ7) a low enable freezes the pins
  freeze_pins_a: assert property (@(posedge mclk) disable iff (rst) // RQ7
    !clk_en |=> $stable(dac_clk) && $stable(dac_data) && $stable(dac_latch))
    else $error("pins moved while enable low");

  // (RQ13) stop bit held high to the end
  stop_high_a: assert property (@(posedge mclk) disable iff (rst) // RQ13
    (r_ff.busy && r_ff.mode && r_ff.bitn >= dsip_pkg::FRAME_BITS - 5'h01) |-> dac_data)
    else $error("stop bit not high");

endmodule

`default_nettype wire

// ==== hw/dsip_pkg.sv ====
// dsip_pkg: constants for the host controller of the dac serial input port
// assumes a 125 MHz system clock; the link clock is made from it by division in dsip_host
package dsip_pkg;
  // word layout
  localparam int WORD_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int OVERSAMPLE = 16;
  // system clock and link rates
  localparam int MCLK_HZ = 125000000;
  localparam int SPI_SCK_HZ = 1000000;
  localparam int ASYNC_CLK_HZ = 2400000;
  // half periods in mclk cycles; the typical three-wire half period is rounded down
  localparam int SPI_HALF_MAX = MCLK_HZ / (2 * SPI_SCK_HZ);
  // async rate is a ceiling, so round the half period up and stay below it
  localparam int ASYNC_HALF_MAX = (MCLK_HZ + 2 * ASYNC_CLK_HZ - 1) / (2 * ASYNC_CLK_HZ);
  localparam logic [7:0] SPI_HALF = 8'(SPI_HALF_MAX);
  localparam logic [7:0] ASYNC_HALF = 8'(ASYNC_HALF_MAX);
  // async frame: start + 16 data + stop
  localparam logic [4:0] FRAME_BITS = 5'h12;
  localparam logic [4:0] LAST_SPI_BIT = 5'h0F;
  localparam logic [3:0] LAST_TICK = 4'hF;
endpackage

// ==== tb/dsip_dev_model.sv ====
// dsip_dev_model: behavioural serial input port of the dac
// assumes pins resolved to wire levels by the bench; mode comes from a strap
`timescale 1ns/1ps
`default_nettype none
module dsip_dev_model (
  // pins
  input wire logic sclk,
  input wire logic din,
  input wire logic latch,
  input wire logic async_sel,
  // observation
  output logic sdo,
  output logic [15:0] dac_word,
  output logic [7:0] loads
);
  logic [15:0] sr = 16'h0000;
  logic [8:0] cnt = 9'h000;
  logic act = 1'b0;
  assign sdo = sr[15];
  initial begin
    dac_word = 16'h0000;
    loads = 8'h00;
  end
  // shift, or find start and sample bit centres
  always @(posedge sclk) begin
    if (!async_sel) begin
      sr <= {sr[14:0], din};
    end else if (!act) begin
      act <= !din;
      cnt <= 9'h001;
    end else begin
      cnt <= cnt + 9'h001;
      if (cnt[3:0] == 4'h8 && cnt[8:4] >= 5'h01 && cnt[8:4] <= 5'h10) begin
        sr <= {sr[14:0], din};
      end
      // a low stop bit drops the frame
      if (cnt == 9'h118) begin
        act <= 1'b0;
        if (din) begin
          dac_word <= sr;
          loads <= loads + 8'h01;
        end
      end
    end
  end
  always @(posedge latch) begin
    if (!async_sel) begin
      dac_word <= sr;
      loads <= loads + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ==== tb/dsip_host_tb.sv ====
// dsip_host_tb: self-checking bench for the host driver of the dac input port
// assumes dsip_host and dsip_dev_model are compiled before this file
`timescale 1ns/1ps
`default_nettype none
module dsip_host_tb;
  logic mclk, rst, clk_en, async_mode, wr_req, busy, wr_done, dac_data, dac_clk;
  logic dac_latch, dac_latch_oe, dac_sdo, sdo_word_valid, latch_w;
  logic [15:0] wr_word, sdo_word, dac_word, prev;
  logic [7:0] loads;
  int fails, comparisons;
  // latch wire: pull-up strap in async mode, otherwise the host drives it
  assign latch_w = dac_latch_oe ? dac_latch : async_mode;
  dsip_host dut (.mclk(mclk), .rst(rst), .clk_en(clk_en), .async_mode(async_mode),
    .wr_req(wr_req), .wr_word(wr_word), .busy(busy), .wr_done(wr_done),
    .dac_data(dac_data), .dac_clk(dac_clk), .dac_latch(dac_latch),
    .dac_latch_oe(dac_latch_oe), .dac_sdo(dac_sdo), .sdo_word_valid(sdo_word_valid),
    .sdo_word(sdo_word));
  dsip_dev_model dev (.sclk(dac_clk), .din(dac_data), .latch(latch_w),
    .async_sel(async_mode), .sdo(dac_sdo), .dac_word(dac_word), .loads(loads));
  // system clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic start(input logic mode, input logic [15:0] w);
    @(posedge mclk);
    #1;
    async_mode = mode;
    wr_word = w;
    wr_req = 1'b1;
    @(posedge mclk);
    #1;
    wr_req = 1'b0;
  endtask
  // bounded wait; async frames need about 15k cycles
  task automatic wait_done;
    int n;
    for (n = 0; n < 40000 && wr_done !== 1'b1; n++) begin
      @(posedge mclk);
      #1;
    end
    if (n == 40000) begin
      fails++;
      summarize();
    end
  endtask
  // three-wire word with a second request refused while busy
  task automatic t_three(input logic [15:0] w);
    logic [7:0] l0;
    l0 = loads;
    start(1'b0, w);
    repeat (200) @(posedge mclk);
    #1;
    chk("busy", 16'h0001, {15'h0000, busy});
    #1;
    chk("latch", 16'h0000, {15'h0000, latch_w});
    wr_word = ~w;
    wr_req = 1'b1;
    @(posedge mclk);
    #1;
    wr_req = 1'b0;
    wait_done();
    chk("sdo valid", 16'h0001, {15'h0000, sdo_word_valid});
    @(posedge mclk);
    #1;
    chk("dac word", w, dac_word);
    chk("loads", {8'h00, l0 + 8'h01}, {8'h00, loads});
    chk("clk idle", 16'h0000, {15'h0000, dac_clk});
    chk("sdo word", prev, sdo_word);
    prev = w;
    $display("three-wire test done");
  endtask
  // word with the enable dropped mid-word: the link must freeze, then finish
  task automatic t_freeze(input logic [15:0] w);
    logic c;
    start(1'b0, w);
    repeat (100) @(posedge mclk);
    #1;
    c = dac_clk;
    clk_en = 1'b0;
    repeat (300) @(posedge mclk);
    #1;
    chk("frozen clk", {15'h0000, c}, {15'h0000, dac_clk});
    chk("frozen busy", 16'h0001, {15'h0000, busy});
    clk_en = 1'b1;
    wait_done();
    @(posedge mclk);
    #1;
    chk("dac word", w, dac_word);
    chk("sdo word", prev, sdo_word);
    prev = w;
    $display("freeze test done");
  endtask
  // reset in mid-word, then a clean word
  task automatic t_reset(input logic [15:0] w);
    start(1'b0, w);
    repeat (500) @(posedge mclk);
    #1;
    rst = 1'b1;
    @(posedge mclk);
    #1;
    chk("reset busy", 16'h0000, {15'h0000, busy});
    chk("reset clk", 16'h0000, {15'h0000, dac_clk});
    chk("reset data", 16'h0001, {15'h0000, dac_data});
    rst = 1'b0;
    @(posedge mclk);
    #1;
    chk("reset done", 16'h0000, {15'h0000, wr_done});
    start(1'b0, w);
    wait_done();
    @(posedge mclk);
    #1;
    chk("dac word", w, dac_word);
    $display("reset test done");
  endtask
  // framed async word, latch left to the pull-up
  task automatic t_async(input logic [15:0] w);
    start(1'b1, w);
    repeat (50) @(posedge mclk);
    #1;
    chk("latch oe", 16'h0000, {15'h0000, dac_latch_oe});
    wait_done();
    chk("sdo valid", 16'h0000, {15'h0000, sdo_word_valid});
    @(posedge mclk);
    #1;
    chk("async word", w, dac_word);
    prev = w;
    $display("async test done");
  endtask
  initial begin
    fails = 0;
    comparisons = 0;
    rst = 1'b1;
    clk_en = 1'b1;
    async_mode = 1'b0;
    wr_req = 1'b0;
    wr_word = 16'h0000;
    prev = 16'h0000;
    repeat (5) @(posedge mclk);
    #1;
    rst = 1'b0;
    t_three(16'hA55A);
    t_three(16'h0001);
    t_async(16'h8001);
    t_freeze(16'h1234);
    t_three(16'hFF00);
    t_reset(16'h5AA5);
    summarize();
  end
endmodule
`default_nettype wire
